/* File: verilog/rcbs_pkg.sv */
// Purpose: Shared constants for reset configuration and bus pin routing.
// Assumes: 16-bit IO port space, one 25 MHz core clock.
// Notes:   Field positions of the routing register live here; addr_gpio_a also hard-codes bits 5:0.
package rcbs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] RCBS_ROUTING_ADDR = 16'h1C00;
    localparam logic [14:0] RCBS_ROUTING_RESET = 15'h0000;
    localparam int unsigned RCBS_RSVD_BIT = 15;
    localparam logic RCBS_RSVD_VALUE = 1'b0;

    // ------------------------------------------------------------
    // Field layout of the routing register
    // ------------------------------------------------------------
    localparam int unsigned RCBS_PAR_LSB = 12;
    localparam int unsigned RCBS_PAR_W = 3;
    localparam int unsigned RCBS_SP1_LSB = 10;
    localparam int unsigned RCBS_SP2_LSB = 8;
    localparam int unsigned RCBS_SP_W = 2;
    localparam int unsigned RCBS_ADDR_GPIO_LSB = 0;
    localparam int unsigned RCBS_ADDR_GPIO_W = 6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Consecutive cycles the regulator must sit above threshold
    localparam int unsigned RCBS_SUPPLY_FILTER_CYCLES = 4;

    // Types
    typedef logic [RCBS_PAR_W-1:0] rcbs_par_mode_t;
    typedef logic [RCBS_SP_W-1:0] rcbs_sp_mode_t;

endpackage

/* File: verilog/rcbs_sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow static levels; no bus coherency needed.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module rcbs_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Two stages to settle metastability
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

/* File: verilog/rcbs_top.sv */
// Purpose: Reset configuration straps and external bus pin routing.
// Assumes: I_RST_B is the external reset pin; comparator is analogue.
// Notes:   Clock muxing itself is outside; this block drives selects.
`timescale 1ns/1ps

module rcbs_top #(
    parameter int unsigned SUPPLY_FILTER_CYCLES =
        rcbs_pkg::RCBS_SUPPLY_FILTER_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_CORE_REGULATOR_ENABLE_PIN,
    input wire logic I_CORE_REGULATOR_OUTPUT_ABOVE,
    input wire logic I_CLOCK_SOURCE_SELECT,
    input wire logic [15:0] I_IO_ADDR,
    input wire logic I_IO_WR,
    input wire logic I_IO_RD,
    input wire logic [15:0] I_IO_WDATA,
    output logic [15:0] O_IO_RDATA,
    output logic O_SUPPLY_GOOD,
    output logic O_CORE_RESET_B,
    output logic O_SYSCLK_FROM_EXTERNAL,
    output logic O_RTC_FROM_OSCILLATOR,
    output rcbs_pkg::rcbs_par_mode_t O_PARALLEL_PORT_MODE,
    output rcbs_pkg::rcbs_sp_mode_t O_SERIAL_PORT1_MODE,
    output rcbs_pkg::rcbs_sp_mode_t O_SERIAL_PORT2_MODE,
    output logic [5:0] O_ADDR_PIN_GENERAL_IO
);
    import rcbs_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = $clog2(SUPPLY_FILTER_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX =
        CNT_W'(SUPPLY_FILTER_CYCLES - 1);

    logic [2:0] pins_s;
    logic reg_bypass_s;
    logic volt_above_s;
    logic clk_sel_s;
    logic [CNT_W-1:0] filt_cnt_q;
    logic [CNT_W-1:0] filt_cnt_d;
    logic supply_good_q;
    logic supply_good_d;
    logic core_reset_b_q;
    logic sysclk_ext_q;
    logic rtc_osc_q;
    logic [14:0] routing_q;
    logic [14:0] routing_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic wr_hit;
    logic rd_hit;
    logic [15:0] read_word;
    logic volt_ok;

    // Address decode shared by reads and writes
    function automatic logic port_hit(input logic [15:0] addr);
        port_hit = (addr == RCBS_ROUTING_ADDR);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Straps and comparator are asynchronous to the core clock
    rcbs_sync2 #(
        .WIDTH(3)
    ) u_pin_sync (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_async({I_CORE_REGULATOR_ENABLE_PIN,
                  I_CORE_REGULATOR_OUTPUT_ABOVE,
                  I_CLOCK_SOURCE_SELECT}),
        .o_sync(pins_s)
    );

    assign reg_bypass_s = pins_s[2];
    assign volt_above_s = pins_s[1];
    assign clk_sel_s = pins_s[0];

    // ------------------------------------------------------------
    // Supply good and internal reset
    // ------------------------------------------------------------
    // Filter rejects comparator chatter near the threshold
    assign volt_ok = volt_above_s && (filt_cnt_q == CNT_MAX);
    assign filt_cnt_d = !volt_above_s ? '0 :
                        volt_ok ? filt_cnt_q :
                        filt_cnt_q + CNT_W'(1);
    // Bypass forces good; otherwise wait for filtered threshold
    assign supply_good_d = reg_bypass_s || volt_ok;

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            filt_cnt_q <= '0;
            supply_good_q <= 1'b0;
        end else begin
            filt_cnt_q <= filt_cnt_d;
            supply_good_q <= supply_good_d;
        end
    end

    // Pin reset clears this flop; release waits for supply good
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            core_reset_b_q <= 1'b0;
        end else begin
            core_reset_b_q <= supply_good_q;
        end
    end

    // ------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------
    // Strap is static, so a glitch-free mux downstream is enough
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sysclk_ext_q <= 1'b0;
            rtc_osc_q <= 1'b0;
        end else begin
            sysclk_ext_q <= clk_sel_s;
            rtc_osc_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Routing register on the IO port
    // ------------------------------------------------------------
    assign wr_hit = I_IO_WR && port_hit(I_IO_ADDR);
    assign rd_hit = I_IO_RD && port_hit(I_IO_ADDR);
    // Only bits below the reserved one are stored
    assign routing_d = wr_hit ? I_IO_WDATA[14:0] : routing_q;
    assign read_word = {RCBS_RSVD_VALUE, routing_q};
    // Unmapped reads answer zero; idle cycles keep last answer
    assign rdata_d = rd_hit ? read_word :
                     I_IO_RD ? 16'h0000 : rdata_q;

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            routing_q <= RCBS_ROUTING_RESET;
            rdata_q <= 16'h0000;
        end else begin
            routing_q <= routing_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Routing fields are the register itself: effect next cycle
    assign O_PARALLEL_PORT_MODE =
        routing_q[RCBS_PAR_LSB +: RCBS_PAR_W];
    assign O_SERIAL_PORT1_MODE = routing_q[RCBS_SP1_LSB +: RCBS_SP_W];
    assign O_SERIAL_PORT2_MODE = routing_q[RCBS_SP2_LSB +: RCBS_SP_W];
    // One bit per address pin; bit 0 is the lowest pin
    assign O_ADDR_PIN_GENERAL_IO =
        routing_q[RCBS_ADDR_GPIO_LSB +: RCBS_ADDR_GPIO_W];
    assign O_IO_RDATA = rdata_q;
    assign O_SUPPLY_GOOD = supply_good_q;
    assign O_CORE_RESET_B = core_reset_b_q;
    assign O_SYSCLK_FROM_EXTERNAL = sysclk_ext_q;
    assign O_RTC_FROM_OSCILLATOR = rtc_osc_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    good_needs_volt_a: assert property (
        !reg_bypass_s && $past(!reg_bypass_s) && $rose(supply_good_q)
        |-> $past(volt_above_s))
        else $error("supply good rose without threshold");

    reset_and_a: assert property (
        core_reset_b_q |-> $past(supply_good_q))
        else $error("core reset released without supply good");

    bypass_good_a: assert property (
        reg_bypass_s |=> supply_good_q)
        else $error("bypass did not force supply good");

    sole_reset_a: assert property (
        reg_bypass_s |-> ##2 core_reset_b_q)
        else $error("reset pin not sole source in bypass");

    // Sampled reset pin keeps the release edge, still in reset, out
    clk_low_a: assert property (
        I_RST_B && !clk_sel_s |=> !sysclk_ext_q && rtc_osc_q)
        else $error("oscillator not driving system clock");

    clk_high_a: assert property (
        clk_sel_s |=> sysclk_ext_q && rtc_osc_q)
        else $error("external clock not selected");

    write_next_a: assert property (
        wr_hit |=> O_PARALLEL_PORT_MODE ==
            $past(I_IO_WDATA[RCBS_PAR_LSB +: RCBS_PAR_W])
            && O_SERIAL_PORT1_MODE ==
            $past(I_IO_WDATA[RCBS_SP1_LSB +: RCBS_SP_W]))
        else $error("routing did not follow write");

    addr_gpio_a: assert property (
        wr_hit |=> O_ADDR_PIN_GENERAL_IO == $past(I_IO_WDATA[5:0]))
        else $error("address pin select not updated");

    rsvd_read_a: assert property (
        rd_hit |=> O_IO_RDATA[RCBS_RSVD_BIT] == RCBS_RSVD_VALUE
            && O_IO_RDATA[14:0] == $past(routing_q))
        else $error("reserved bit or readback wrong");

    unmapped_read_a: assert property (
        I_IO_RD && !port_hit(I_IO_ADDR) |=> O_IO_RDATA == 16'h0000)
        else $error("unmapped read not zero");

    hold_value_a: assert property (
        !wr_hit |=> $stable(routing_q))
        else $error("routing changed without write");

endmodule

/* File: tb/rcbs_board_model.sv */
// Purpose: Board straps and supply comparator seen by the routing block.
// Assumes: Strap requests come from the bench; comparator is a level.
// Notes:   Straps follow requests only while reset is held.
`timescale 1ns/1ps
module rcbs_board_model (
    input wire logic i_rst_b,
    input wire logic i_reg_off_req,
    input wire logic i_clk_ext_req,
    input wire logic i_above_req,
    output logic o_reg_off,
    output logic o_clk_ext,
    output logic o_above
);
    // ------------------------------------------------------------
    // Strap latches
    // ------------------------------------------------------------
    // Transparent in reset only, so a change never lands mid-run
    always_latch begin
        if (!i_rst_b) begin
            o_reg_off = i_reg_off_req;
            o_clk_ext = i_clk_ext_req;
        end
    end
    // Comparator level passes straight through
    assign o_above = i_above_req;
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for strap handling and pin routing.
// Assumes: One 25 MHz clock; register strobes are one-cycle pulses.
// Notes:   Expected values come from package field constants.
`timescale 1ns/1ps
module testbench;
    import rcbs_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic off_req = 1'b1, ext_req = 1'b1, above_req = 1'b0;
    logic reg_off, clk_ext, above, sg, core_b, sys_ext, rtc_osc;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, v;
    rcbs_par_mode_t par;
    rcbs_sp_mode_t sp1, sp2;
    logic [5:0] gpio;
    logic [15:0] pats [3] = '{16'hFFFF, 16'h5A5A, 16'h25C3};
    int fails = 0, tests_run = 0, cycles = 0;

    rcbs_board_model rcbs_board_model_inst (.i_rst_b(rst_b),
        .i_reg_off_req(off_req), .i_clk_ext_req(ext_req),
        .i_above_req(above_req), .o_reg_off(reg_off),
        .o_clk_ext(clk_ext), .o_above(above));
    rcbs_top rcbs_top_inst (.I_CLK(clk), .I_RST_B(rst_b),
        .I_CORE_REGULATOR_ENABLE_PIN(reg_off),
        .I_CORE_REGULATOR_OUTPUT_ABOVE(above),
        .I_CLOCK_SOURCE_SELECT(clk_ext), .I_IO_ADDR(addr),
        .I_IO_WR(wr), .I_IO_RD(rd), .I_IO_WDATA(wdata),
        .O_IO_RDATA(rdata), .O_SUPPLY_GOOD(sg), .O_CORE_RESET_B(core_b),
        .O_SYSCLK_FROM_EXTERNAL(sys_ext), .O_RTC_FROM_OSCILLATOR(rtc_osc),
        .O_PARALLEL_PORT_MODE(par), .O_SERIAL_PORT1_MODE(sp1),
        .O_SERIAL_PORT2_MODE(sp2), .O_ADDR_PIN_GENERAL_IO(gpio));

    // ------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    // A hung wait would otherwise never reach the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Straps are chosen while reset is held, then reset is let go
    task automatic do_reset(input logic off, input logic ext);
        @(posedge clk);
        rst_b <= 1'b0;
        off_req <= off;
        ext_req <= ext;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task automatic io_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic chk_route(input logic [15:0] p);
        check(16'(par), 16'(p[RCBS_PAR_LSB +: RCBS_PAR_W]));
        check(16'(sp1), 16'(p[RCBS_SP1_LSB +: RCBS_SP_W]));
        check(16'(sp2), 16'(p[RCBS_SP2_LSB +: RCBS_SP_W]));
        check(16'(gpio),
            16'(p[RCBS_ADDR_GPIO_LSB +: RCBS_ADDR_GPIO_W]));
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        // Regulator bypassed, external clock selected
        do_reset(1'b1, 1'b1);
        // Two sync edges, then supply good on the third edge
        repeat (3) @(negedge clk);
        check(16'(sg), 16'h0000);
        @(negedge clk);
        check(16'(sg), 16'h0001);
        check(16'(core_b), 16'h0000);
        @(negedge clk);
        check(16'(core_b), 16'h0001);
        check(16'(sys_ext), 16'h0001);
        check(16'(rtc_osc), 16'h0001);
        $display("test bypass done");
        // Register reset value, field routing and reserved bit
        io_rd(RCBS_ROUTING_ADDR, v);
        check(v, {RCBS_RSVD_VALUE, RCBS_ROUTING_RESET});
        foreach (pats[i]) begin
            // No routed peripheral runs here: gated before, reset after
            io_wr(RCBS_ROUTING_ADDR, pats[i]);
            chk_route(pats[i]);
            io_rd(RCBS_ROUTING_ADDR, v);
            check(v, {RCBS_RSVD_VALUE, pats[i][14:0]});
        end
        // Other addresses neither write nor answer
        io_wr(16'h1C01, 16'h0000);
        io_rd(16'h1C01, v);
        check(v, 16'h0000);
        repeat (20) @(negedge clk);
        chk_route(pats[2]);
        $display("test routing done");
        // Regulator enabled, oscillator clock, comparator low
        do_reset(1'b0, 1'b0);
        #1 check(16'(core_b), 16'h0000);
        chk_route(16'h0000);
        repeat (20) @(negedge clk);
        check(16'(sg), 16'h0000);
        check(16'(core_b), 16'h0000);
        check(16'(sys_ext), 16'h0000);
        check(16'(rtc_osc), 16'h0001);
        @(posedge clk);
        above_req <= 1'b1;
        // Sync plus filter keeps supply good low for a while
        repeat (RCBS_SUPPLY_FILTER_CYCLES) @(negedge clk);
        check(16'(sg), 16'h0000);
        // Two sync edges plus the filter count: rises on that edge
        repeat (2) @(negedge clk);
        check(16'(sg), 16'h0000);
        @(negedge clk);
        check(16'(sg), 16'h0001);
        @(negedge clk);
        check(16'(core_b), 16'h0001);
        @(posedge clk);
        above_req <= 1'b0;
        // Drop passes the two sync edges, then clears on the next
        repeat (3) @(negedge clk);
        check(16'(sg), 16'h0001);
        @(negedge clk);
        check(16'(sg), 16'h0000);
        @(negedge clk);
        check(16'(core_b), 16'h0000);
        $display("test regulator done");
        test_done();
    end
endmodule
